// file: cpu_status_flag_unit_bench.sv
// self-checking bench for the cpu status flag unit
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module cpu_status_flag_unit_bench;
    logic                clk;
    logic                nrst;
    csfu_pkg::csfu_apb_s apb_req;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    csfu_pkg::csfu_req_s core_req;
    csfu_pkg::csfu_br_e  br_sel;
    logic                br_val;
    logic [13:0]         irq_req;
    logic [13:0]         irq_en;
    logic [7:0]          status;
    logic [7:0]          result;
    logic                decimal_mode;
    logic                index_mode;
    logic                br_taken;
    logic                busy;
    logic                irq_ack;
    logic [13:0]         irq_clr;
    logic                push_valid;
    logic [7:0]          push_byte;
    int                  err_count;
    int                  total_checks;
    logic [31:0]         rd;
    logic                er;

    csfu_top #(.NSRC(14)) uut (.clk(clk), .nrst(nrst), .apb_req(apb_req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_req(core_req), .br_sel(br_sel), .br_val(br_val), .irq_req(irq_req),
        .irq_en(irq_en), .processor_status(status), .result(result), .decimal_mode(decimal_mode),
        .index_mode(index_mode), .br_taken(br_taken), .busy(busy), .irq_ack(irq_ack), .irq_clr(irq_clr),
        .push_valid(push_valid), .push_byte(push_byte));

    // 250 mhz core clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // verdict, reached from the end of the run or from a spent wait
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic hang(input string what);
        err_count++;
        $display("wrong value %s exp done got timeout", what);
        summarize();
    endtask

    // one core op for a single edge, then back to idle
    task automatic do_op(input logic [4:0] code, input logic [7:0] a, input logic [7:0] b, input logic sh);
        @(posedge clk);
        core_req <= '{csfu_pkg::csfu_op_e'(code), a, b, sh};
        @(posedge clk);
        core_req <= '{csfu_pkg::csfu_op_e'(5'h00), 8'h00, 8'h00, 1'b0};
        @(negedge clk);
    endtask

    // apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) hang("pready");
        rd = prdata;
        er = pslverr;
        apb_req <= '{1'b0, 1'b0, 1'b0, 12'h000, 32'h0000_0000};
        @(negedge clk);
    endtask

    task automatic wait_push;
        int n;
        for (n = 0; n < 8 && push_valid !== 1'b1; n++) @(negedge clk);
        if (n == 8) hang("push_valid");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        `CHK("status", 8'h04, status)
        apb(1'b0, 12'h000, 32'h0000_0000);
        `CHK("prdata", 32'h0000_0004, rd)
        $display("test reset done");
    endtask

    // masked source waits; unmasking lets the lowest index in; break ignores the mask
    task automatic t_irq;
        @(posedge clk);
        irq_en <= 14'h3fff;
        irq_req <= 14'h0028;
        repeat (5) begin
            @(negedge clk);
            `CHK("masked entry", 1'b0, push_valid | irq_ack)
        end
        do_op(5'h09, 8'h00, 8'h00, 1'b0);
        wait_push();
        `CHK("push byte", 8'h00, push_byte)
        @(negedge clk);
        `CHK("ack", 1'b1, irq_ack)
        `CHK("clr", 14'h0008, irq_clr)
        `CHK("busy", 1'b1, busy)
        @(posedge clk);
        irq_req <= 14'h0000;
        @(negedge clk);
        `CHK("mask set", 1'b1, status[2])
        `CHK("idle", 1'b0, busy)
        apb(1'b1, 12'h000, 32'h0000_0004);
        do_op(5'h10, 8'h00, 8'h00, 1'b0);
        wait_push();
        `CHK("break push", 8'h14, push_byte)
        @(negedge clk);
        `CHK("break ack", 1'b1, irq_ack)
        `CHK("break clr", 14'h0000, irq_clr)
        @(negedge clk);
        `CHK("live b", 8'h04, status)
        apb(1'b0, 12'h004, 32'h0000_0000);
        `CHK("push reg", 32'h0000_0014, rd)
        $display("test irq done");
    endtask

    // binary then decimal arithmetic; result registers on the same edge as the flags, so the extra wait is spare
    task automatic t_arith;
        do_op(5'h07, 8'h00, 8'h00, 1'b0);
        do_op(5'h01, 8'h7f, 8'h01, 1'b0);
        @(negedge clk);
        `CHK("adc res", 8'h80, result)
        `CHK("adc flags", 8'hc4, status)
        do_op(5'h01, 8'hff, 8'h01, 1'b0);
        `CHK("wrap flags", 8'h07, status)
        do_op(5'h02, 8'h80, 8'h01, 1'b0);
        @(negedge clk);
        `CHK("sub res", 8'h7f, result)
        `CHK("sub flags", 8'h45, status)
        do_op(5'h03, 8'h00, 8'h00, 1'b0);
        `CHK("load zero", 2'b01, {status[7], status[1]})
        do_op(5'h04, 8'h80, 8'h00, 1'b0);
        `CHK("shift", 3'b100, {status[7], status[1], status[0]})
        do_op(5'h05, 8'h00, 8'hc0, 1'b0);
        `CHK("bit test", 3'b111, {status[7], status[6], status[1]})
        do_op(5'h0a, 8'h00, 8'h00, 1'b0);
        `CHK("dec on", 1'b1, decimal_mode)
        do_op(5'h07, 8'h00, 8'h00, 1'b0);
        do_op(5'h01, 8'h19, 8'h28, 1'b0);
        @(negedge clk);
        `CHK("bcd add", 8'h47, result)
        do_op(5'h06, 8'h00, 8'h00, 1'b0);
        do_op(5'h02, 8'h40, 8'h01, 1'b0);
        @(negedge clk);
        `CHK("bcd sub", 9'h139, {status[0], result})
        do_op(5'h05, 8'h40, 8'h40, 1'b0);
        `CHK("bit in dec", 3'b010, {status[7], status[6], status[1]})
        do_op(5'h0b, 8'h00, 8'h00, 1'b0);
        `CHK("dec off", 1'b0, decimal_mode)
        $display("test arith done");
    endtask

    // every dedicated set and clear op; mask ends set so nothing is taken
    task automatic t_flags;
        logic [4:0] codes[9] = '{5'h06, 5'h07, 5'h09, 5'h08, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e};
        int         bits[9]  = '{0, 0, 2, 2, 3, 3, 5, 5, 6};
        logic       vals[9]  = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 9; i++) begin
            do_op(codes[i], 8'h00, 8'h00, 1'b0);
            `CHK("flag op", vals[i], status[bits[i]])
            if (i == 6) `CHK("index mode", 1'b1, index_mode)
        end
        `CHK("index off", 1'b0, index_mode)
        // stack pull loads every stored flag, break stays zero
        do_op(5'h0f, 8'h00, 8'hff, 1'b0);
        `CHK("pull", 8'hef, status)
        $display("test flags done");
    endtask

    // branch tests on all-set and all-clear result flags, then bus refusals
    task automatic t_branch;
        logic [7:0] pat[2] = '{8'hd7, 8'h04};
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, 12'h000, {24'h00_0000, pat[p]});
            apb(1'b0, 12'h000, 32'h0000_0000);
            `CHK("readback", {24'h00_0000, pat[p] & 8'hef}, rd)
            for (int s = 0; s < 8; s++) begin
                @(posedge clk);
                br_sel <= csfu_pkg::csfu_br_e'(s[1:0]);
                br_val <= s[2];
                @(negedge clk);
                `CHK("branch", s[2] == (p == 0), br_taken)
            end
        end
        apb(1'b1, 12'h004, 32'h0000_00ff);
        `CHK("ro write err", 1'b1, er)
        apb(1'b0, 12'h008, 32'h0000_0000);
        `CHK("unmapped err", 1'b1, er)
        $display("test branch done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // reset held six cycles, then the scenarios in turn
    initial begin
        err_count = 0;
        total_checks = 0;
        nrst = 1'b0;
        apb_req = '0;
        core_req = '0;
        br_sel = csfu_pkg::csfu_br_e'(2'h0);
        br_val = 1'b0;
        irq_req = 14'h0000;
        irq_en = 14'h0000;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        t_reset();
        t_irq();
        t_arith();
        t_flags();
        t_branch();
        summarize();
    end
endmodule

// file: csfu_alu.sv
// binary and decimal add/subtract with carry and overflow
`timescale 1ns/10ps
module csfu_alu (
    input  wire logic       sub,
    input  wire logic       dec,
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       cin,
    output logic [7:0]      res,
    output logic            cout,
    output logic            ovf
);
    logic [7:0] bx;
    logic [8:0] bin;
    logic [4:0] lo_s;
    logic [4:0] hi_s;
    logic       lo_c;
    logic       hi_c;
    logic       lo_fix;
    logic       hi_fix;
    logic [3:0] adj;
    logic [3:0] lo_r;
    logic [3:0] hi_r;

    // subtract is add of the complement, carry set means no borrow
    assign bx  = sub ? ~b : b;
    assign bin = {1'b0, a} + {1'b0, bx} + {8'h00, cin};
    assign ovf = (a[7] == bx[7]) && (bin[7] != a[7]);

    // nibble sums for decimal correction
    assign lo_s = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    assign lo_c = sub ? lo_s[4] : (lo_s > csfu_pkg::CSFU_BCD_MAX);
    assign hi_s = {1'b0, a[7:4]} + {1'b0, bx[7:4]} + {4'h0, lo_c};
    assign hi_c = sub ? hi_s[4] : (hi_s > csfu_pkg::CSFU_BCD_MAX);

    // add corrects on carry, subtract corrects on borrow
    assign lo_fix = sub ? !lo_c : lo_c;
    assign hi_fix = sub ? !hi_c : hi_c;
    assign adj    = sub ? csfu_pkg::CSFU_BCD_SUB : csfu_pkg::CSFU_BCD_ADD;
    assign lo_r   = lo_s[3:0] + (lo_fix ? adj : csfu_pkg::CSFU_NIB0);
    assign hi_r   = hi_s[3:0] + (hi_fix ? adj : csfu_pkg::CSFU_NIB0);

    // overflow stays binary in decimal mode, it carries no meaning there
    assign res  = dec ? {hi_r, lo_r} : bin[7:0];
    assign cout = dec ? hi_c : bin[8];
endmodule

// file: csfu_flag_bit.sv
// one status flag flip-flop with load, set and clear
`timescale 1ns/10ps
module csfu_flag_bit #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic ld,
    input  wire logic d,
    input  wire logic set,
    input  wire logic clr,
    output logic      q
);
    logic q_r;
    logic q_nxt;

    // full load beats set, set beats clear
    assign q_nxt = ld ? d : (set ? 1'b1 : (clr ? 1'b0 : q_r));
    assign q     = q_r;

    // flag storage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_r <= RST_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule

// file: csfu_pkg.sv
// shared constants, types and encodings for the cpu status flag unit
package csfu_pkg;
    // status byte layout
    localparam int unsigned CSFU_W = 8;
    localparam int unsigned CSFU_C = 0;
    localparam int unsigned CSFU_Z = 1;
    localparam int unsigned CSFU_I = 2;
    localparam int unsigned CSFU_D = 3;
    localparam int unsigned CSFU_B = 4;
    localparam int unsigned CSFU_T = 5;
    localparam int unsigned CSFU_V = 6;
    localparam int unsigned CSFU_N = 7;
    localparam logic [7:0]  CSFU_STATUS_RST = 8'h04;
    localparam logic [7:0]  CSFU_B_MASK     = 8'h10;
    localparam logic [7:0]  CSFU_ZERO8      = 8'h00;

    // decimal correction
    localparam logic [4:0]  CSFU_BCD_MAX = 5'h09;
    localparam logic [3:0]  CSFU_BCD_ADD = 4'h6;
    localparam logic [3:0]  CSFU_BCD_SUB = 4'hA;
    localparam logic [3:0]  CSFU_NIB0    = 4'h0;

    // apb map
    localparam int unsigned CSFU_AW         = 12;
    localparam logic [11:0] CSFU_OFF_STATUS = 12'h000;
    localparam logic [11:0] CSFU_OFF_PUSH   = 12'h004;

    typedef enum logic [4:0] {
        CSFU_OP_NOP                  = 5'h00,
        CSFU_OP_ADC                  = 5'h01,
        CSFU_OP_SUBTRACT_WITH_BORROW = 5'h02,
        CSFU_OP_LOAD                 = 5'h03,
        CSFU_OP_SHIFT                = 5'h04,
        CSFU_OP_BIT                  = 5'h05,
        CSFU_OP_CARRY_SET            = 5'h06,
        CSFU_OP_CARRY_CLEAR          = 5'h07,
        CSFU_OP_IRQ_MASK_SET         = 5'h08,
        CSFU_OP_IRQ_MASK_CLEAR       = 5'h09,
        CSFU_OP_DECIMAL_ON           = 5'h0A,
        CSFU_OP_DECIMAL_OFF          = 5'h0B,
        CSFU_OP_INDEX_MODE_ON        = 5'h0C,
        CSFU_OP_INDEX_MODE_OFF       = 5'h0D,
        CSFU_OP_OVERFLOW_CLEAR       = 5'h0E,
        CSFU_OP_PULL                 = 5'h0F,
        CSFU_OP_SOFTWARE_BREAK       = 5'h10
    } csfu_op_e;

    typedef enum logic [1:0] {
        CSFU_BR_C = 2'h0,
        CSFU_BR_Z = 2'h1,
        CSFU_BR_V = 2'h2,
        CSFU_BR_N = 2'h3
    } csfu_br_e;

    typedef enum logic [2:0] {
        CSFU_IDLE  = 3'b001,
        CSFU_PUSH  = 3'b010,
        CSFU_ENTER = 3'b100
    } csfu_st_e;

    // one core request per cycle
    typedef struct packed {
        csfu_op_e   op;
        logic [7:0] a;
        logic [7:0] b;
        logic       sh_c;
    } csfu_req_s;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } csfu_apb_s;
endpackage

// file: csfu_top.sv
// cpu status flag unit: flags, interrupt gating and apb access
// How it works
// - eight-bit status: four result, three control flags, one break
// - branches test carry, zero, overflow, negative
// - zero/overflow/negative unreliable in decimal mode
// - carry from arithmetic, shifts and rotates
// - zero set on zero result, else cleared
// - mask blocks all but software break
// - decimal flag selects bcd corrected arithmetic
// - only add/subtract with carry use decimal
// - break bit reads zero in live register
// - break entry pushes status with break set
// - index mode enables memory-to-memory operations
// - overflow on signed byte range exceed
// - bit test copies operand bit 6 to overflow
// - negative follows result most significant bit
// - bit test copies operand bit 7 to negative
// - dedicated set/clear ops per allowed flag
// - irq taken when request, enable, mask clear
// - entry pushes, sets mask, clears request
`timescale 1ns/10ps
module csfu_top #(
    parameter int unsigned NSRC = 14
) (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  csfu_pkg::csfu_apb_s      apb_req,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  csfu_pkg::csfu_req_s      core_req,
    input  csfu_pkg::csfu_br_e       br_sel,
    input  wire logic                br_val,
    input  wire logic [NSRC-1:0]     irq_req,
    input  wire logic [NSRC-1:0]     irq_en,
    output logic [7:0]               processor_status,
    output logic [7:0]               result,
    output logic                     decimal_mode,
    output logic                     index_mode,
    output logic                     br_taken,
    output logic                     busy,
    output logic                     irq_ack,
    output logic [NSRC-1:0]          irq_clr,
    output logic                     push_valid,
    output logic [7:0]               push_byte
);
    ////////////////////////////////////////////////////////////////
    logic [7:0]      flag_q;
    logic [7:0]      ld_v;
    logic [7:0]      d_v;
    logic [7:0]      set_v;
    logic [7:0]      clr_v;
    logic [7:0]      ld_src;
    logic [7:0]      res_zn;
    logic [7:0]      alu_res;
    logic            alu_c;
    logic            alu_v;
    logic            is_adc;
    logic            is_sub_borrow;
    logic            is_arith;
    logic            is_load;
    logic            is_shift;
    logic            is_bit;
    logic            is_pull;
    logic            is_swbrk;
    logic            apb_acc;
    logic            hit_status;
    logic            hit_push;
    logic            apb_wr;
    logic            ld_all;
    logic [NSRC-1:0] pend_raw;
    logic [NSRC-1:0] pend;
    logic [NSRC-1:0] pick;
    logic            go_irq;
    logic            go_swbrk;
    csfu_pkg::csfu_st_e st_r;
    csfu_pkg::csfu_st_e st_nxt;
    logic [NSRC-1:0] irq_clr_r;
    logic [NSRC-1:0] irq_clr_nxt;
    logic            push_valid_r;
    logic [7:0]      push_byte_r;
    logic [7:0]      push_byte_nxt;
    logic [7:0]      result_r;
    logic [31:0]     prdata_r;
    logic [31:0]     prdata_nxt;

    ////////////////////////////////////////////////////////////////
    // op decode
    assign is_adc   = core_req.op == csfu_pkg::CSFU_OP_ADC;
    assign is_sub_borrow = core_req.op == csfu_pkg::CSFU_OP_SUBTRACT_WITH_BORROW;
    assign is_arith = is_adc | is_sub_borrow;
    assign is_load  = core_req.op == csfu_pkg::CSFU_OP_LOAD;
    assign is_shift = core_req.op == csfu_pkg::CSFU_OP_SHIFT;
    assign is_bit   = core_req.op == csfu_pkg::CSFU_OP_BIT;
    assign is_pull  = core_req.op == csfu_pkg::CSFU_OP_PULL;
    assign is_swbrk = core_req.op == csfu_pkg::CSFU_OP_SOFTWARE_BREAK;

    // decimal flag only reaches the adder, so other ops ignore it
    csfu_alu u_alu (
        .sub  (is_sub_borrow),
        .dec  (flag_q[csfu_pkg::CSFU_D]),
        .a    (core_req.a),
        .b    (core_req.b),
        .cin  (flag_q[csfu_pkg::CSFU_C]),
        .res  (alu_res),
        .cout (alu_c),
        .ovf  (alu_v)
    );

    ////////////////////////////////////////////////////////////////
    // apb decode, zero wait states
    assign apb_acc  = apb_req.psel & apb_req.penable;
    assign hit_status = apb_req.paddr == csfu_pkg::CSFU_OFF_STATUS;
    assign hit_push = apb_req.paddr == csfu_pkg::CSFU_OFF_PUSH;
    assign apb_wr   = apb_acc & apb_req.pwrite & hit_status;
    assign pready   = 1'b1;
    assign pslverr  = apb_acc & ~(hit_status | (hit_push & ~apb_req.pwrite));
    assign prdata   = prdata_r;
    assign prdata_nxt = hit_status ? {24'h00_0000, flag_q}
                      : (hit_push ? {24'h00_0000, push_byte_r} : 32'h0000_0000);

    // read data captured in the setup phase
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata_r <= 32'h0000_0000;
        end else if (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) begin
            prdata_r <= prdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // full loads: software write wins over a stack pull in the same cycle
    assign ld_all = apb_wr | is_pull;
    assign ld_src = apb_wr ? apb_req.pwdata[7:0] : core_req.b;
    assign res_zn = is_arith ? alu_res : core_req.a;

    // carry
    assign ld_v[csfu_pkg::CSFU_C]  = ld_all | is_arith | is_shift;
    assign d_v[csfu_pkg::CSFU_C]   = ld_all ? ld_src[csfu_pkg::CSFU_C]
                                   : (is_arith ? alu_c : core_req.sh_c);
    assign set_v[csfu_pkg::CSFU_C] = core_req.op == csfu_pkg::CSFU_OP_CARRY_SET;
    assign clr_v[csfu_pkg::CSFU_C] = core_req.op == csfu_pkg::CSFU_OP_CARRY_CLEAR;

    // zero, from the decimal-corrected result in decimal mode
    assign ld_v[csfu_pkg::CSFU_Z]  = ld_all | is_arith | is_load | is_shift | is_bit;
    assign d_v[csfu_pkg::CSFU_Z]   = ld_all ? ld_src[csfu_pkg::CSFU_Z]
                                   : (is_bit ? ((core_req.a & core_req.b) == csfu_pkg::CSFU_ZERO8)
                                   : (res_zn == csfu_pkg::CSFU_ZERO8));
    assign set_v[csfu_pkg::CSFU_Z] = 1'b0;
    assign clr_v[csfu_pkg::CSFU_Z] = 1'b0;

    // interrupt mask, also raised on every entry
    assign ld_v[csfu_pkg::CSFU_I]  = ld_all;
    assign d_v[csfu_pkg::CSFU_I]   = ld_src[csfu_pkg::CSFU_I];
    assign set_v[csfu_pkg::CSFU_I] = (core_req.op == csfu_pkg::CSFU_OP_IRQ_MASK_SET)
                                   | (st_r == csfu_pkg::CSFU_PUSH);
    assign clr_v[csfu_pkg::CSFU_I] = core_req.op == csfu_pkg::CSFU_OP_IRQ_MASK_CLEAR;

    // decimal
    assign ld_v[csfu_pkg::CSFU_D]  = ld_all;
    assign d_v[csfu_pkg::CSFU_D]   = ld_src[csfu_pkg::CSFU_D];
    assign set_v[csfu_pkg::CSFU_D] = core_req.op == csfu_pkg::CSFU_OP_DECIMAL_ON;
    assign clr_v[csfu_pkg::CSFU_D] = core_req.op == csfu_pkg::CSFU_OP_DECIMAL_OFF;

    // break has no storage
    assign ld_v[csfu_pkg::CSFU_B]  = 1'b0;
    assign d_v[csfu_pkg::CSFU_B]   = 1'b0;
    assign set_v[csfu_pkg::CSFU_B] = 1'b0;
    assign clr_v[csfu_pkg::CSFU_B] = 1'b0;

    // index mode
    assign ld_v[csfu_pkg::CSFU_T]  = ld_all;
    assign d_v[csfu_pkg::CSFU_T]   = ld_src[csfu_pkg::CSFU_T];
    assign set_v[csfu_pkg::CSFU_T] = core_req.op == csfu_pkg::CSFU_OP_INDEX_MODE_ON;
    assign clr_v[csfu_pkg::CSFU_T] = core_req.op == csfu_pkg::CSFU_OP_INDEX_MODE_OFF;

    // overflow, clear only
    assign ld_v[csfu_pkg::CSFU_V]  = ld_all | is_arith | is_bit;
    assign d_v[csfu_pkg::CSFU_V]   = ld_all ? ld_src[csfu_pkg::CSFU_V]
                                   : (is_bit ? core_req.b[csfu_pkg::CSFU_V] : alu_v);
    assign set_v[csfu_pkg::CSFU_V] = 1'b0;
    assign clr_v[csfu_pkg::CSFU_V] = core_req.op == csfu_pkg::CSFU_OP_OVERFLOW_CLEAR;

    // negative
    assign ld_v[csfu_pkg::CSFU_N]  = ld_all | is_arith | is_load | is_shift | is_bit;
    assign d_v[csfu_pkg::CSFU_N]   = ld_all ? ld_src[csfu_pkg::CSFU_N]
                                   : (is_bit ? core_req.b[csfu_pkg::CSFU_N]
                                   : res_zn[csfu_pkg::CSFU_N]);
    assign set_v[csfu_pkg::CSFU_N] = 1'b0;
    assign clr_v[csfu_pkg::CSFU_N] = 1'b0;

    ////////////////////////////////////////////////////////////////
    // seven stored flags, break position is a constant zero
    for (genvar gi = 0; gi < csfu_pkg::CSFU_W; gi++) begin : g_flag
        if (gi == csfu_pkg::CSFU_B) begin : g_break
            assign flag_q[gi] = 1'b0;
        end else begin : g_ff
            csfu_flag_bit #(
                .RST_VAL (csfu_pkg::CSFU_STATUS_RST[gi])
            ) u_bit (
                .clk  (clk),
                .nrst (nrst),
                .ld   (ld_v[gi]),
                .d    (d_v[gi]),
                .set  (set_v[gi]),
                .clr  (clr_v[gi]),
                .q    (flag_q[gi])
            );
        end
    end

    // status views for the datapath and the branch unit
    assign processor_status = flag_q;
    assign decimal_mode     = flag_q[csfu_pkg::CSFU_D];
    assign index_mode       = flag_q[csfu_pkg::CSFU_T];
    assign br_taken = (br_sel == csfu_pkg::CSFU_BR_C) ? (flag_q[csfu_pkg::CSFU_C] == br_val)
                    : (br_sel == csfu_pkg::CSFU_BR_Z) ? (flag_q[csfu_pkg::CSFU_Z] == br_val)
                    : (br_sel == csfu_pkg::CSFU_BR_V) ? (flag_q[csfu_pkg::CSFU_V] == br_val)
                    : (flag_q[csfu_pkg::CSFU_N] == br_val);

    // arithmetic result register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            result_r <= 8'h00;
        end else if (is_arith) begin
            result_r <= alu_res;
        end
    end
    assign result = result_r;

    ////////////////////////////////////////////////////////////////
    // interrupt entry: lowest index wins; break ignores the mask
    assign pend_raw = irq_req & irq_en;
    assign pend     = flag_q[csfu_pkg::CSFU_I] ? '0 : pend_raw;
    assign pick     = pend & (~pend + {{(NSRC-1){1'b0}}, 1'b1});
    assign go_swbrk = (st_r == csfu_pkg::CSFU_IDLE) & is_swbrk;
    assign go_irq   = (st_r == csfu_pkg::CSFU_IDLE) & ~is_swbrk & (|pend);

    // push byte carries break set only for the software break
    assign push_byte_nxt = go_swbrk ? (flag_q | csfu_pkg::CSFU_B_MASK) : flag_q;
    assign irq_clr_nxt   = (st_r == csfu_pkg::CSFU_IDLE) & go_irq ? pick : irq_clr_r;

    // next state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            csfu_pkg::CSFU_IDLE: begin
                if (go_swbrk | go_irq) begin
                    st_nxt = csfu_pkg::CSFU_PUSH;
                end
            end
            csfu_pkg::CSFU_PUSH: begin
                st_nxt = csfu_pkg::CSFU_ENTER;
            end
            csfu_pkg::CSFU_ENTER: begin
                st_nxt = csfu_pkg::CSFU_IDLE;
            end
            default: begin
                st_nxt = csfu_pkg::CSFU_IDLE;
            end
        endcase
    end

    // state and push register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r         <= csfu_pkg::CSFU_IDLE;
            push_valid_r <= 1'b0;
            push_byte_r  <= 8'h00;
        end else begin
            st_r         <= st_nxt;
            push_valid_r <= go_swbrk | go_irq;
            push_byte_r  <= (go_swbrk | go_irq) ? push_byte_nxt : push_byte_r;
        end
    end

    // serviced request clear, one cycle in the enter state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_clr_r <= '0;
        end else begin
            irq_clr_r <= (st_r == csfu_pkg::CSFU_PUSH) ? irq_clr_r : (go_irq ? irq_clr_nxt : '0);
        end
    end

    assign irq_clr    = (st_r == csfu_pkg::CSFU_ENTER) ? irq_clr_r : '0;
    assign irq_ack    = st_r == csfu_pkg::CSFU_ENTER;
    assign busy       = st_r != csfu_pkg::CSFU_IDLE;
    assign push_valid = push_valid_r;
    assign push_byte  = push_byte_r;

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic [8:0] chk_sum;
    logic [7:0] chk_a;
    logic       chk_b6;
    logic       chk_bcd;
    logic       chk_plain;
    assign chk_sum   = {1'b0, core_req.a} + {1'b0, core_req.b} + {8'h00, flag_q[csfu_pkg::CSFU_C]};
    assign chk_a     = core_req.a;
    assign chk_b6    = core_req.b[6];
    assign chk_bcd   = (core_req.a[3:0] < 4'hA) && (core_req.a[7:4] < 4'hA)
                    && (core_req.b[3:0] < 4'hA) && (core_req.b[7:4] < 4'hA);
    assign chk_plain = ~apb_wr & (st_r == csfu_pkg::CSFU_IDLE);

    a_break_bit_zero: assert property (processor_status[4] == 1'b0) else $error("break bit set");
    a_irq_gate_mask: assert property (st_r == csfu_pkg::CSFU_IDLE && !is_swbrk && flag_q[2]
        |=> st_r == csfu_pkg::CSFU_IDLE) else $error("irq taken while masked");
    a_entry_sets_mask: assert property (go_irq |=> ##1 flag_q[2] && irq_ack && $onehot(irq_clr))
        else $error("entry did not mask or clear");
    a_break_push_flag: assert property (go_swbrk |=> push_valid && push_byte[4] ##1 irq_ack && irq_clr == '0)
        else $error("break push wrong");
    a_adc_bin_carry: assert property (is_adc && !flag_q[3] && chk_plain
        |=> flag_q[0] == $past(chk_sum[8])) else $error("binary carry wrong");
    a_load_zero_neg: assert property (is_load && chk_plain
        |=> flag_q[1] == ($past(chk_a) == 8'h00) && flag_q[7] == $past(chk_a[7])) else $error("load z/n wrong");
    a_bit_ovf_copy: assert property (is_bit && chk_plain |=> flag_q[6] == $past(chk_b6))
        else $error("bit test overflow wrong");
    a_overflow_clears: assert property (core_req.op == csfu_pkg::CSFU_OP_OVERFLOW_CLEAR && chk_plain |=> !flag_q[6])
        else $error("overflow not cleared");
    a_dec_bcd_out: assert property (is_adc && flag_q[3] && chk_bcd
        |=> result[3:0] < 4'hA && result[7:4] < 4'hA) else $error("decimal result not bcd");

    c_break_entry: cover property (go_swbrk ##2 irq_ack);
    c_irq_entry: cover property (go_irq ##2 irq_ack);
    c_dec_add: cover property (is_adc && flag_q[3] && alu_c);
    c_apb_write: cover property (apb_wr);
endmodule
